// ===== verilog/ttc_regs.vh
`ifndef TTC_REGS_VH
`define TTC_REGS_VH
// How it works
// - Clock counting advances every 12 clocks, or every 4 with the fast bit.
// - Reset clears all three fast bits, so timers start at divide by 12.
// - Count pins sampled at C4; a high then low sample counts one edge.
// - Count registers change at C3, one machine cycle after the edge.
// - Mode bit 2 picks timer A source, bit 6 timer B; 1 means pin.
// - Timers A and B each pick one of four modes independently.
// - Mode 0: 13 bits, low five bits prescale the high byte.
// - Mode 0 high byte steps on low bit 4 fall; wrap sets overflow.
// - Counting needs run set and gate clear or interrupt pin high.
// - Mode 1: 16 bit counter, wrap from FFFF sets overflow.
// - Mode 2: low byte wraps, sets overflow, reloads from unchanged high.
// - Timer B in mode 3 freezes its count.
// - Timer A mode 3: low byte uses A controls, high byte uses B run/flag.
// - With A in mode 3, B counts without run bit or overflow flag.
// - A and B overflow flags clear on their interrupt vector acknowledge.
// - Timer C counts pin edges or clock/12 or /4, gated by its run bit.
// - Capture mode: 16 bit up counter, wrap sets timer C overflow.
// - Trigger pin fall, when enabled, captures count and sets external flag.
// - Auto clear bit zeroes timer C after each capture.
// - Timer C request is OR of its flags; only software clears them.
// - Reset clears counts, modes and controls; all timers stopped.

// Register offsets
`define TTC_ADDR_MODE 8'h00
`define TTC_ADDR_CTRL 8'h01
`define TTC_ADDR_A_LOW 8'h02
`define TTC_ADDR_A_HIGH 8'h03
`define TTC_ADDR_B_LOW 8'h04
`define TTC_ADDR_B_HIGH 8'h05
`define TTC_ADDR_CLKCTL 8'h06
`define TTC_ADDR_C_CTRL 8'h07
`define TTC_ADDR_C_MODE 8'h08
`define TTC_ADDR_C_LOW 8'h09
`define TTC_ADDR_C_HIGH 8'h0A
`define TTC_ADDR_CAP_LOW 8'h0B
`define TTC_ADDR_CAP_HIGH 8'h0C

// timer_mode_reg fields
`define TTC_MODE_A_LO 0
`define TTC_MODE_A_HI 1
`define TTC_MODE_A_SEL 2
`define TTC_MODE_A_GATE 3
`define TTC_MODE_B_LO 4
`define TTC_MODE_B_HI 5
`define TTC_MODE_B_SEL 6
`define TTC_MODE_B_GATE 7

// timer_control_reg fields
`define TTC_CTRL_A_RUN 4
`define TTC_CTRL_A_OVF 5
`define TTC_CTRL_B_RUN 6
`define TTC_CTRL_B_OVF 7

// clock_control_reg fields
`define TTC_CLK_A_FAST 0
`define TTC_CLK_B_FAST 1
`define TTC_CLK_C_FAST 2

// timer_c_control fields
`define TTC_C_CAPSEL 0
`define TTC_C_SRC 1
`define TTC_C_RUN 2
`define TTC_C_EXTEN 3
`define TTC_C_EXTF 6
`define TTC_C_OVF 7

// timer_c_mode_reg fields
`define TTC_CM_AUTOCLR 3

// Reset values
`define TTC_RST_BYTE 8'h00
`define TTC_RST_CLKCTL 8'h00

// Machine cycle timing: four phases, slow rate is three machine cycles
`define TTC_PHASE_C3 2'h2
`define TTC_PHASE_C4 2'h3
`define TTC_SLOW_LAST 2'h2

// Operating modes of timers A and B
`define TTC_MODE0 2'h0
`define TTC_MODE1 2'h1
`define TTC_MODE2 2'h2
`define TTC_MODE3 2'h3
`endif

// ===== verilog/ttc_pin_sample.v
`timescale 1ns/1ns
// Pin synchroniser with a per-machine-cycle sampler and fall detector
module ttc_pin_sample (
   input wire core_clk_in,
   input wire rst_n_in,
   input wire pin_in,
   input wire sample_in,
   output wire level_out,
   output wire fall_out
);
   reg sync1_ff;
   reg sync2_ff;
   reg smp_ff;
   reg fall_ff;

   // Two-stage synchroniser; only sync2_ff is looked at downstream
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync1_ff <= 1'b1;
         sync2_ff <= 1'b1;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
      end
   end

   // Sample once per machine cycle; fall flag holds for a whole cycle
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         smp_ff <= 1'b1;
         fall_ff <= 1'b0;
      end else if (sample_in) begin
         smp_ff <= sync2_ff;
         fall_ff <= smp_ff & ~sync2_ff;
      end
   end

   assign level_out = sync2_ff;
   assign fall_out = fall_ff;
endmodule

// ===== verilog/ttc_top.v
`timescale 1ns/1ns
`include "ttc_regs.vh"
module ttc_top #(
   parameter ADDR_W = 8,
   parameter NUM_PINS = 6
) (
   input wire core_clk_in,
   input wire rst_n_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire [7:0] wr_data_in,
   input wire wr_strobe_in,
   input wire rd_strobe_in,
   output wire [7:0] rd_data_out,
   input wire timer_a_count_pin_in,
   input wire timer_b_count_pin_in,
   input wire timer_c_count_pin_in,
   input wire timer_c_trigger_pin_in,
   input wire ext_irq_a_pin_in,
   input wire ext_irq_b_pin_in,
   input wire vector_a_ack_in,
   input wire vector_b_ack_in,
   output wire timer_a_irq_out,
   output wire timer_b_irq_out,
   output wire timer_c_irq_out
);
   // Step of modes 0 to 2: returns {overflow, high, low}
   function [16:0] ttc_step;
      input [1:0] mode;
      input [7:0] th;
      input [7:0] tl;
      reg [5:0] lo5;
      reg [8:0] hi9;
      reg [8:0] lo9;
      begin
         lo5 = {1'b0, tl[4:0]} + 6'h01;
         hi9 = lo5[5] ? ({1'b0, th} + 9'h001) : {1'b0, th};
         lo9 = {1'b0, tl} + 9'h001;
         case (mode)
            `TTC_MODE0: begin
               // Upper three low bits stay as written
               ttc_step = {hi9[8], hi9[7:0], tl[7:5], lo5[4:0]};
            end
            `TTC_MODE1: begin
               ttc_step = {1'b0, th, tl} + 17'h0_0001;
            end
            `TTC_MODE2: begin
               // Reload keeps the high byte untouched
               ttc_step = lo9[8] ? {1'b1, th, th} : {1'b0, th, lo9[7:0]};
            end
            default: begin
               ttc_step = {1'b0, th, tl};
            end
         endcase
      end
   endfunction

   // Address match for writes
   function wr_hit;
      input [ADDR_W-1:0] addr;
      input [7:0] target;
      begin
         wr_hit = (addr == target[ADDR_W-1:0]);
      end
   endfunction

   reg [1:0] phase_ff;
   reg [1:0] slow_ff;
   reg [7:0] mode_ff;
   reg [7:0] ctrl_ff;
   reg [7:0] clkctl_ff;
   reg [7:0] c_ctrl_ff;
   reg [7:0] c_mode_ff;
   reg [7:0] a_lo_ff;
   reg [7:0] a_hi_ff;
   reg [7:0] b_lo_ff;
   reg [7:0] b_hi_ff;
   reg [7:0] c_lo_ff;
   reg [7:0] c_hi_ff;
   reg [7:0] cap_lo_ff;
   reg [7:0] cap_hi_ff;
   reg [7:0] rd_data_ff;
   reg irq_a_ff;
   reg irq_b_ff;
   reg irq_c_ff;

   reg [7:0] nxt_ctrl;
   reg [7:0] nxt_c_ctrl;
   reg [7:0] nxt_a_lo;
   reg [7:0] nxt_a_hi;
   reg [7:0] nxt_b_lo;
   reg [7:0] nxt_b_hi;
   reg [7:0] nxt_c_lo;
   reg [7:0] nxt_c_hi;
   reg [7:0] nxt_cap_lo;
   reg [7:0] nxt_cap_hi;
   reg [7:0] nxt_rd_data;
   reg set_ovf_a;
   reg set_ovf_b;
   reg set_ovf_c;
   reg set_extf_c;
   reg [16:0] step_a;
   reg [16:0] step_b;
   reg [16:0] sum_c;
   reg [8:0] sum8;

   wire [NUM_PINS-1:0] pin_raw;
   wire [NUM_PINS-1:0] pin_lvl;
   wire [NUM_PINS-1:0] pin_fall;
   wire is_c3;
   wire is_c4;
   wire slow_tick;
   wire tick_a;
   wire tick_b;
   wire tick_c;
   wire [1:0] mode_a;
   wire [1:0] mode_b;
   wire a_in_m3;
   wire en_a;
   wire en_b;
   wire inc_a;
   wire inc_b;
   wire inc_c;
   wire inc_a_hi3;
   wire cap_evt;
   wire capsel;

   // Pin order: count A, count B, irq A, irq B, count C, trigger C
   assign pin_raw = {timer_c_trigger_pin_in, timer_c_count_pin_in, ext_irq_b_pin_in,
                     ext_irq_a_pin_in, timer_b_count_pin_in, timer_a_count_pin_in};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
         ttc_pin_sample u_smp (
            .core_clk_in(core_clk_in),
            .rst_n_in(rst_n_in),
            .pin_in(pin_raw[gi]),
            .sample_in(is_c4),
            .level_out(pin_lvl[gi]),
            .fall_out(pin_fall[gi])
         );
      end
   endgenerate

   // Machine cycle of four phases; slow counter divides three cycles
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         phase_ff <= 2'h0;
         slow_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
         if (is_c4) begin
            slow_ff <= (slow_ff == `TTC_SLOW_LAST) ? 2'h0 : (slow_ff + 2'h1);
         end
      end
   end

   assign is_c3 = (phase_ff == `TTC_PHASE_C3);
   assign is_c4 = (phase_ff == `TTC_PHASE_C4);
   assign slow_tick = is_c3 & (slow_ff == `TTC_SLOW_LAST);

   // Clock ticks: every C3 when fast, every third C3 otherwise
   assign tick_a = clkctl_ff[`TTC_CLK_A_FAST] ? is_c3 : slow_tick;
   assign tick_b = clkctl_ff[`TTC_CLK_B_FAST] ? is_c3 : slow_tick;
   assign tick_c = clkctl_ff[`TTC_CLK_C_FAST] ? is_c3 : slow_tick;

   assign mode_a = {mode_ff[`TTC_MODE_A_HI], mode_ff[`TTC_MODE_A_LO]};
   assign mode_b = {mode_ff[`TTC_MODE_B_HI], mode_ff[`TTC_MODE_B_LO]};
   assign a_in_m3 = (mode_a == `TTC_MODE3);

   // Gate logic; timer B loses its run bit while A is split
   assign en_a = ctrl_ff[`TTC_CTRL_A_RUN] & (~mode_ff[`TTC_MODE_A_GATE] | pin_lvl[2]);
   assign en_b = (a_in_m3 | ctrl_ff[`TTC_CTRL_B_RUN]) &
                 (~mode_ff[`TTC_MODE_B_GATE] | pin_lvl[3]);

   // Pin edges are applied at C3 of the cycle after the C4 sample
   assign inc_a = en_a & (mode_ff[`TTC_MODE_A_SEL] ? (is_c3 & pin_fall[0]) : tick_a);
   assign inc_b = en_b & (mode_b != `TTC_MODE3) &
                  (mode_ff[`TTC_MODE_B_SEL] ? (is_c3 & pin_fall[1]) : tick_b);
   assign inc_a_hi3 = a_in_m3 & ctrl_ff[`TTC_CTRL_B_RUN] & tick_a;

   // Timer C is only active in capture mode; reload modes are absent
   assign capsel = c_ctrl_ff[`TTC_C_CAPSEL];
   assign inc_c = c_ctrl_ff[`TTC_C_RUN] & capsel &
                  (c_ctrl_ff[`TTC_C_SRC] ? (is_c3 & pin_fall[4]) : tick_c);
   assign cap_evt = capsel & c_ctrl_ff[`TTC_C_EXTEN] & is_c3 & pin_fall[5];

   // Timer A next state
   always @* begin
      nxt_a_lo = a_lo_ff;
      nxt_a_hi = a_hi_ff;
      set_ovf_a = 1'b0;
      set_ovf_b = 1'b0;
      step_a = ttc_step(mode_a, a_hi_ff, a_lo_ff);
      sum8 = {1'b0, a_lo_ff} + 9'h001;
      if (a_in_m3) begin
         // Two independent 8-bit counters
         if (inc_a) begin
            nxt_a_lo = sum8[7:0];
            set_ovf_a = sum8[8];
         end
         if (inc_a_hi3) begin
            nxt_a_hi = a_hi_ff + 8'h01;
            set_ovf_b = (a_hi_ff == 8'hFF);
         end
      end else if (inc_a) begin
         {set_ovf_a, nxt_a_hi, nxt_a_lo} = step_a;
      end
      // Software write overrides the same-cycle count
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_A_LOW)) begin
         nxt_a_lo = wr_data_in;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_A_HIGH)) begin
         nxt_a_hi = wr_data_in;
      end
   end

   // Timer B next state and shared control flags
   always @* begin
      nxt_b_lo = b_lo_ff;
      nxt_b_hi = b_hi_ff;
      step_b = ttc_step(mode_b, b_hi_ff, b_lo_ff);
      if (inc_b) begin
         nxt_b_hi = step_b[15:8];
         nxt_b_lo = step_b[7:0];
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_B_LOW)) begin
         nxt_b_lo = wr_data_in;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_B_HIGH)) begin
         nxt_b_hi = wr_data_in;
      end
      // Overflow set beats vector acknowledge; low nibble reads zero
      nxt_ctrl = ctrl_ff;
      if (vector_a_ack_in) begin
         nxt_ctrl[`TTC_CTRL_A_OVF] = 1'b0;
      end
      if (vector_b_ack_in) begin
         nxt_ctrl[`TTC_CTRL_B_OVF] = 1'b0;
      end
      if (set_ovf_a) begin
         nxt_ctrl[`TTC_CTRL_A_OVF] = 1'b1;
      end
      // Split timer A owns this flag, so B overflow is dropped then
      if (set_ovf_b || (inc_b && step_b[16] && !a_in_m3)) begin
         nxt_ctrl[`TTC_CTRL_B_OVF] = 1'b1;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_CTRL)) begin
         nxt_ctrl = {wr_data_in[7:4], 4'h0};
      end
   end

   // Timer C capture-mode counter
   always @* begin
      nxt_c_lo = c_lo_ff;
      nxt_c_hi = c_hi_ff;
      nxt_cap_lo = cap_lo_ff;
      nxt_cap_hi = cap_hi_ff;
      set_ovf_c = 1'b0;
      set_extf_c = 1'b0;
      sum_c = {1'b0, c_hi_ff, c_lo_ff} + 17'h0_0001;
      if (inc_c) begin
         {set_ovf_c, nxt_c_hi, nxt_c_lo} = sum_c;
      end
      if (cap_evt) begin
         // Capture stores the count before this edge's increment
         nxt_cap_lo = c_lo_ff;
         nxt_cap_hi = c_hi_ff;
         set_extf_c = 1'b1;
         if (c_mode_ff[`TTC_CM_AUTOCLR]) begin
            nxt_c_lo = 8'h00;
            nxt_c_hi = 8'h00;
         end
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_C_LOW)) begin
         nxt_c_lo = wr_data_in;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_C_HIGH)) begin
         nxt_c_hi = wr_data_in;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_CAP_LOW)) begin
         nxt_cap_lo = wr_data_in;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_CAP_HIGH)) begin
         nxt_cap_hi = wr_data_in;
      end
      // Flags stay set until software writes them clear
      nxt_c_ctrl = c_ctrl_ff;
      if (set_ovf_c) begin
         nxt_c_ctrl[`TTC_C_OVF] = 1'b1;
      end
      if (set_extf_c) begin
         nxt_c_ctrl[`TTC_C_EXTF] = 1'b1;
      end
      if (wr_strobe_in && wr_hit(addr_in, `TTC_ADDR_C_CTRL)) begin
         nxt_c_ctrl = {wr_data_in[7:6], 2'h0, wr_data_in[3:0]};
      end
   end

   // Read mux; data stands only in the cycle after the strobe
   always @* begin
      nxt_rd_data = 8'h00;
      if (rd_strobe_in) begin
         case (addr_in)
            `TTC_ADDR_MODE: nxt_rd_data = mode_ff;
            `TTC_ADDR_CTRL: nxt_rd_data = ctrl_ff;
            `TTC_ADDR_A_LOW: nxt_rd_data = a_lo_ff;
            `TTC_ADDR_A_HIGH: nxt_rd_data = a_hi_ff;
            `TTC_ADDR_B_LOW: nxt_rd_data = b_lo_ff;
            `TTC_ADDR_B_HIGH: nxt_rd_data = b_hi_ff;
            `TTC_ADDR_CLKCTL: nxt_rd_data = clkctl_ff;
            `TTC_ADDR_C_CTRL: nxt_rd_data = c_ctrl_ff;
            `TTC_ADDR_C_MODE: nxt_rd_data = c_mode_ff;
            `TTC_ADDR_C_LOW: nxt_rd_data = c_lo_ff;
            `TTC_ADDR_C_HIGH: nxt_rd_data = c_hi_ff;
            `TTC_ADDR_CAP_LOW: nxt_rd_data = cap_lo_ff;
            `TTC_ADDR_CAP_HIGH: nxt_rd_data = cap_hi_ff;
            default: nxt_rd_data = 8'h00;
         endcase
      end
   end

   // Configuration registers written only by software
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         mode_ff <= `TTC_RST_BYTE;
         clkctl_ff <= `TTC_RST_CLKCTL;
         c_mode_ff <= `TTC_RST_BYTE;
      end else if (wr_strobe_in) begin
         if (wr_hit(addr_in, `TTC_ADDR_MODE)) begin
            mode_ff <= wr_data_in;
         end
         if (wr_hit(addr_in, `TTC_ADDR_CLKCTL)) begin
            clkctl_ff <= {5'h00, wr_data_in[2:0]};
         end
         if (wr_hit(addr_in, `TTC_ADDR_C_MODE)) begin
            c_mode_ff <= {4'h0, wr_data_in[3], 3'h0};
         end
      end
   end

   // Counters, flags, capture registers and outputs
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ctrl_ff <= `TTC_RST_BYTE;
         c_ctrl_ff <= `TTC_RST_BYTE;
         a_lo_ff <= `TTC_RST_BYTE;
         a_hi_ff <= `TTC_RST_BYTE;
         b_lo_ff <= `TTC_RST_BYTE;
         b_hi_ff <= `TTC_RST_BYTE;
         c_lo_ff <= `TTC_RST_BYTE;
         c_hi_ff <= `TTC_RST_BYTE;
         cap_lo_ff <= `TTC_RST_BYTE;
         cap_hi_ff <= `TTC_RST_BYTE;
         rd_data_ff <= 8'h00;
         irq_a_ff <= 1'b0;
         irq_b_ff <= 1'b0;
         irq_c_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         c_ctrl_ff <= nxt_c_ctrl;
         a_lo_ff <= nxt_a_lo;
         a_hi_ff <= nxt_a_hi;
         b_lo_ff <= nxt_b_lo;
         b_hi_ff <= nxt_b_hi;
         c_lo_ff <= nxt_c_lo;
         c_hi_ff <= nxt_c_hi;
         cap_lo_ff <= nxt_cap_lo;
         cap_hi_ff <= nxt_cap_hi;
         rd_data_ff <= nxt_rd_data;
         // Requests mirror the flags in the same cycle they change
         irq_a_ff <= nxt_ctrl[`TTC_CTRL_A_OVF];
         irq_b_ff <= nxt_ctrl[`TTC_CTRL_B_OVF];
         irq_c_ff <= nxt_c_ctrl[`TTC_C_OVF] | nxt_c_ctrl[`TTC_C_EXTF];
      end
   end

   assign rd_data_out = rd_data_ff;
   assign timer_a_irq_out = irq_a_ff;
   assign timer_b_irq_out = irq_b_ff;
   assign timer_c_irq_out = irq_c_ff;
endmodule

// ===== tb/ttc_top_assertions.sv
`timescale 1ns/1ns
`include "ttc_regs.vh"
// Port-level checks of the timer block
module ttc_top_assertions #(
   parameter ADDR_W = 8
) (
   input wire core_clk_in,
   input wire rst_n_in,
   input wire [ADDR_W-1:0] addr_in,
   input wire wr_strobe_in,
   input wire rd_strobe_in,
   input wire [7:0] rd_data_out,
   input wire vector_a_ack_in,
   input wire vector_b_ack_in,
   input wire timer_a_irq_out,
   input wire timer_b_irq_out,
   input wire timer_c_irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Causes that may legally drop a flag
   wire ctl_wr = wr_strobe_in && addr_in == `TTC_ADDR_CTRL;
   wire c_wr = wr_strobe_in && addr_in == `TTC_ADDR_C_CTRL;
   wire a_src = vector_a_ack_in || ctl_wr;
   wire b_src = vector_b_ack_in || ctl_wr;
   property p_rst;
      $rose(rst_n_in) |-> {timer_a_irq_out, timer_b_irq_out, timer_c_irq_out} == 3'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("flag up after reset");
   property p_rd_idle;
      !$past(rd_strobe_in) |-> rd_data_out == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_unmapped;
      rd_strobe_in && addr_in > `TTC_ADDR_CAP_HIGH |=> rd_data_out == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctrl_rd;
      rd_strobe_in && ctl_wr == 1'b0 && addr_in == `TTC_ADDR_CTRL |=>
         rd_data_out[3:0] == 4'h0 && rd_data_out[5] == $past(timer_a_irq_out) &&
         rd_data_out[7] == $past(timer_b_irq_out);
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read mismatch");
   property p_cmode_rd;
      rd_strobe_in && addr_in == `TTC_ADDR_C_MODE |=> (rd_data_out & 8'hf7) == 8'h00;
   endproperty
   a_cmode_rd: assert property (p_cmode_rd) else $error("reserved mode bits set");
   property p_c_or;
      rd_strobe_in && addr_in == `TTC_ADDR_C_CTRL |=>
         (rd_data_out[7] | rd_data_out[6]) == $past(timer_c_irq_out);
   endproperty
   a_c_or: assert property (p_c_or) else $error("timer C request not flag OR");
   property p_a_fall;
      rst_n_in && $fell(timer_a_irq_out) |-> $past(a_src);
   endproperty
   a_a_fall: assert property (p_a_fall) else $error("A flag dropped uncaused");
   property p_b_fall;
      rst_n_in && $fell(timer_b_irq_out) |-> $past(b_src);
   endproperty
   a_b_fall: assert property (p_b_fall) else $error("B flag dropped uncaused");
   property p_c_hold;
      // Sampled reset keeps the reset-driven drop out of these checks
      rst_n_in && $fell(timer_c_irq_out) |-> $past(c_wr);
   endproperty
   a_c_hold: assert property (p_c_hold) else $error("C flag cleared by hardware");
   property p_a_ack;
      vector_a_ack_in && !ctl_wr |=> !timer_a_irq_out;
   endproperty
   a_a_ack: assert property (p_a_ack) else $error("A ack left flag set");
   property p_b_ack;
      vector_b_ack_in && !ctl_wr |=> !timer_b_irq_out;
   endproperty
   a_b_ack: assert property (p_b_ack) else $error("B ack left flag set");
   c_a_ovf: cover property ($rose(timer_a_irq_out));
   c_b_ovf: cover property ($rose(timer_b_irq_out));
   c_c_req: cover property ($rose(timer_c_irq_out));
endmodule

// ===== tb/ttc_pin_model.sv
`timescale 1ns/1ns
// Far-side pins: 0 A count, 1 B count, 2 C count, 3 trigger, 4 A gate, 5 B gate
module ttc_pin_model (
   input wire core_clk_in,
   output logic [5:0] pins_out
);
   // Idle high, so the first low is one clean fall
   initial pins_out = 6'h3f;
   // Low held 12 clocks, high 13 between falls, so a period never beats clock over 24
   task automatic falls(input int idx, input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         pins_out[idx] <= 1'b0;
         repeat (12) @(posedge core_clk_in);
         pins_out[idx] <= 1'b1;
         repeat (12) @(posedge core_clk_in);
      end
   endtask
   // Level change, then time for the synchroniser to settle
   task automatic level(input int idx, input logic v);
      @(posedge core_clk_in);
      pins_out[idx] <= v;
      repeat (8) @(posedge core_clk_in);
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ns
`include "ttc_regs.vh"
module tb;
   logic core_clk_in, rst_n_in, wr_strobe_in, rd_strobe_in, vector_a_ack_in, vector_b_ack_in;
   logic [7:0] addr_in, wr_data_in, v0, v1;
   wire [7:0] rd_data_out;
   wire [5:0] pins;
   wire [2:0] irqs;
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   ttc_top uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in),
      .rd_data_out(rd_data_out), .timer_a_count_pin_in(pins[0]),
      .timer_b_count_pin_in(pins[1]), .timer_c_count_pin_in(pins[2]),
      .timer_c_trigger_pin_in(pins[3]), .ext_irq_a_pin_in(pins[4]),
      .ext_irq_b_pin_in(pins[5]), .vector_a_ack_in(vector_a_ack_in),
      .vector_b_ack_in(vector_b_ack_in), .timer_a_irq_out(irqs[0]),
      .timer_b_irq_out(irqs[1]), .timer_c_irq_out(irqs[2]));
   ttc_pin_model pins_m (.core_clk_in(core_clk_in), .pins_out(pins));
   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_strobe_in <= 1'b1;
      @(posedge core_clk_in);
      wr_strobe_in <= 1'b0;
      #1;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_strobe_in <= 1'b1;
      @(posedge core_clk_in);
      rd_strobe_in <= 1'b0;
      #1 v = rd_data_out;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      rd(a, v0);
      chk($sformatf("reg %h", a), e, v0);
   endtask
   // Samples exactly 120 clocks apart, so the step count is exact
   task automatic rate(input logic [7:0] a, input logic [7:0] e);
      rd(a, v0);
      repeat (118) @(posedge core_clk_in);
      rd(a, v1);
      chk($sformatf("steps %h", a), e, v1 - v0);
   endtask
   task automatic wait_irq(input int idx, input int lim);
      int k;
      k = 0;
      while (irqs[idx] !== 1'b1 && k < lim) begin
         @(posedge core_clk_in);
         #1;
         k++;
      end
      chk("irq", 8'h01, {7'h00, irqs[idx]});
   endtask
   task automatic ack(input int idx);
      @(posedge core_clk_in);
      if (idx == 0) vector_a_ack_in <= 1'b1;
      else vector_b_ack_in <= 1'b1;
      @(posedge core_clk_in);
      vector_a_ack_in <= 1'b0;
      vector_b_ack_in <= 1'b0;
      #1;
   endtask
   initial begin
      rst_n_in = 1'b0;
      {wr_strobe_in, rd_strobe_in, vector_a_ack_in, vector_b_ack_in} = 4'h0;
      addr_in = 8'h00;
      wr_data_in = 8'h00;
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      // Every register clears, an unmapped offset reads zero
      for (int a = 0; a <= 12; a++) rc(a[7:0], 8'h00);
      rc(8'h20, 8'h00);
      $display("test reset done");
      wr(`TTC_ADDR_MODE, 8'h01);
      wr(`TTC_ADDR_CTRL, 8'h10);
      rate(`TTC_ADDR_A_LOW, 8'h0a);
      wr(`TTC_ADDR_CLKCTL, 8'h01);
      rate(`TTC_ADDR_A_LOW, 8'h1e);
      wr(`TTC_ADDR_CLKCTL, 8'h00);
      wr(`TTC_ADDR_MODE, 8'h09);
      pins_m.level(4, 1'b0);
      rate(`TTC_ADDR_A_LOW, 8'h00);
      pins_m.level(4, 1'b1);
      rate(`TTC_ADDR_A_LOW, 8'h0a);
      $display("test rates done");
      // Mode 1 wrap, then vector entry clears the flag
      wr(`TTC_ADDR_CTRL, 8'h00);
      wr(`TTC_ADDR_MODE, 8'h01);
      wr(`TTC_ADDR_A_LOW, 8'hff);
      wr(`TTC_ADDR_A_HIGH, 8'hff);
      wr(`TTC_ADDR_CTRL, 8'h10);
      wait_irq(0, 40);
      rc(`TTC_ADDR_A_HIGH, 8'h00);
      rc(`TTC_ADDR_CTRL, 8'h30);
      ack(0);
      chk("irq a", 8'h00, {7'h00, irqs[0]});
      rc(`TTC_ADDR_CTRL, 8'h10);
      // Mode 0: a set upper low bit must not block the 13-bit wrap
      wr(`TTC_ADDR_CTRL, 8'h00);
      wr(`TTC_ADDR_MODE, 8'h00);
      wr(`TTC_ADDR_A_LOW, 8'h3f);
      wr(`TTC_ADDR_A_HIGH, 8'hff);
      wr(`TTC_ADDR_CTRL, 8'h10);
      wait_irq(0, 40);
      rc(`TTC_ADDR_A_LOW, 8'h20);
      rc(`TTC_ADDR_A_HIGH, 8'h00);
      // Mode 2 reload keeps the high byte
      wr(`TTC_ADDR_CTRL, 8'h00);
      wr(`TTC_ADDR_MODE, 8'h02);
      wr(`TTC_ADDR_A_HIGH, 8'h80);
      wr(`TTC_ADDR_A_LOW, 8'hff);
      wr(`TTC_ADDR_CTRL, 8'h10);
      wait_irq(0, 40);
      rc(`TTC_ADDR_A_HIGH, 8'h80);
      rc(`TTC_ADDR_A_LOW, 8'h80);
      ack(0);
      $display("test modes done");
      // Pin counting: five falls give five counts
      wr(`TTC_ADDR_CTRL, 8'h00);
      wr(`TTC_ADDR_MODE, 8'h05);
      wr(`TTC_ADDR_A_LOW, 8'h00);
      wr(`TTC_ADDR_CTRL, 8'h10);
      pins_m.falls(0, 5);
      repeat (24) @(posedge core_clk_in);
      rc(`TTC_ADDR_A_LOW, 8'h05);
      $display("test pin done");
      // Split timer A, frozen and then freed timer B
      wr(`TTC_ADDR_MODE, 8'h33);
      wr(`TTC_ADDR_CTRL, 8'h40);
      rate(`TTC_ADDR_B_LOW, 8'h00);
      rate(`TTC_ADDR_A_HIGH, 8'h0a);
      wr(`TTC_ADDR_MODE, 8'h13);
      wr(`TTC_ADDR_CTRL, 8'h00);
      rate(`TTC_ADDR_B_LOW, 8'h0a);
      rate(`TTC_ADDR_A_HIGH, 8'h00);
      wr(`TTC_ADDR_A_HIGH, 8'hff);
      wr(`TTC_ADDR_CTRL, 8'h40);
      wait_irq(1, 40);
      ack(1);
      chk("irq b", 8'h00, {7'h00, irqs[1]});
      wr(`TTC_ADDR_MODE, 8'h00);
      wr(`TTC_ADDR_CTRL, 8'h00);
      $display("test split done");
      // Timer B fast rate, then its gate pin held low
      wr(`TTC_ADDR_MODE, 8'h90);
      wr(`TTC_ADDR_CLKCTL, 8'h02);
      wr(`TTC_ADDR_CTRL, 8'h40);
      rate(`TTC_ADDR_B_LOW, 8'h1e);
      pins_m.level(5, 1'b0);
      rate(`TTC_ADDR_B_LOW, 8'h00);
      pins_m.level(5, 1'b1);
      wr(`TTC_ADDR_CTRL, 8'h00);
      // Timer C rates, wrap, flags left to software
      wr(`TTC_ADDR_C_CTRL, 8'h05);
      rate(`TTC_ADDR_C_LOW, 8'h0a);
      wr(`TTC_ADDR_CLKCTL, 8'h04);
      rate(`TTC_ADDR_C_LOW, 8'h1e);
      wr(`TTC_ADDR_CLKCTL, 8'h00);
      wr(`TTC_ADDR_C_CTRL, 8'h01);
      wr(`TTC_ADDR_C_LOW, 8'hff);
      wr(`TTC_ADDR_C_HIGH, 8'hff);
      wr(`TTC_ADDR_C_CTRL, 8'h05);
      wait_irq(2, 40);
      ack(0);
      ack(1);
      chk("irq c", 8'h01, {7'h00, irqs[2]});
      wr(`TTC_ADDR_C_CTRL, 8'h01);
      chk("irq c", 8'h00, {7'h00, irqs[2]});
      // Capture of a held count, then auto clear
      wr(`TTC_ADDR_C_LOW, 8'h34);
      wr(`TTC_ADDR_C_HIGH, 8'h12);
      wr(`TTC_ADDR_C_MODE, 8'h08);
      wr(`TTC_ADDR_C_CTRL, 8'h09);
      pins_m.falls(3, 1);
      wait_irq(2, 40);
      rc(`TTC_ADDR_CAP_LOW, 8'h34);
      rc(`TTC_ADDR_CAP_HIGH, 8'h12);
      rc(`TTC_ADDR_C_LOW, 8'h00);
      rc(`TTC_ADDR_C_HIGH, 8'h00);
      rc(`TTC_ADDR_C_CTRL, 8'h49);
      // Pin-sourced timer C; the external flag stays pending
      wr(`TTC_ADDR_C_CTRL, 8'h47);
      pins_m.falls(2, 3);
      repeat (24) @(posedge core_clk_in);
      rc(`TTC_ADDR_C_LOW, 8'h03);
      $display("test timer c done");
      // Mid-run reset drops the pending request
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rc(`TTC_ADDR_C_CTRL, 8'h00);
      chk("irq c", 8'h00, {7'h00, irqs[2]});
      $display("test rereset done");
      close_out();
   end
endmodule
bind ttc_top ttc_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_strobe_in(wr_strobe_in),
   .rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
   .vector_a_ack_in(vector_a_ack_in), .vector_b_ack_in(vector_b_ack_in),
   .timer_a_irq_out(timer_a_irq_out), .timer_b_irq_out(timer_b_irq_out),
   .timer_c_irq_out(timer_c_irq_out));
